/* rtl/pdc_burst_mover.sv */
/*
 * Splits one transfer into fixed 32-byte bursts and times it.
 * Assumes the fabric sink sits on the same clock; burst_valid is held until burst_ready answers it.
 */
`include "pdc_defines.svh"

module pdc_burst_mover
    import pdc_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    pdc_dma_if.mover   dma,
    output logic       burst_valid,
    input  wire logic  burst_ready,
    output logic       burst_to_host,
    output logic [31:0] burst_host_addr,
    output logic [31:0] burst_sram_addr
);
    pdc_mover_state_type state;
    logic [31:0]         remaining;
    logic [31:0]         moved;
    logic                done;
    logic [31:0]         cycles;

    wire logic take = burst_valid && burst_ready;
    wire logic last = take && (remaining == `PDC_BURST_BYTES);

    assign burst_valid = (state == PDC_MOVER_RUN);
    assign dma.busy    = (state == PDC_MOVER_RUN);
    assign dma.done    = done;
    assign dma.cycles  = cycles;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state           <= PDC_MOVER_IDLE;
            remaining       <= `PDC_REG_RESET;
            moved           <= `PDC_REG_RESET;
            done            <= 1'b0;
            cycles          <= `PDC_REG_RESET;
            burst_to_host   <= 1'b0;
            burst_host_addr <= `PDC_REG_RESET;
            burst_sram_addr <= `PDC_REG_RESET;
        end else begin
            case (state)
                PDC_MOVER_IDLE: begin
                    if (dma.start) begin
                        state           <= PDC_MOVER_RUN;
                        remaining       <= dma.length;
                        moved           <= `PDC_REG_RESET;
                        done            <= 1'b0;
                        cycles          <= `PDC_REG_RESET;
                        burst_to_host   <= dma.to_host;
                        burst_host_addr <= dma.base;
                        burst_sram_addr <= `PDC_REG_RESET;
                    end
                end
                PDC_MOVER_RUN: begin
                    cycles <= cycles + 32'h00000001;
                    if (take) begin
                        remaining       <= remaining - `PDC_BURST_BYTES;
                        moved           <= moved + `PDC_BURST_BYTES;
                        burst_host_addr <= burst_host_addr + `PDC_BURST_BYTES;
                        burst_sram_addr <= burst_sram_addr + `PDC_BURST_BYTES;
                    end
                    if (last) begin
                        state <= PDC_MOVER_IDLE;
                        done  <= 1'b1;
                    end
                end
                default: state <= PDC_MOVER_IDLE;
            endcase
        end
    end

    AST_BURST_STEP: assert property (@(posedge clk) disable iff (!rst_n)
        take && !last |=> burst_host_addr == $past(burst_host_addr) + `PDC_BURST_BYTES)
        else $error("burst address did not advance by 32 bytes");

    AST_EXACT_LENGTH: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(done) |-> moved == $past(remaining) + $past(moved))
        else $error("transfer finished with wrong byte count");

    AST_BASE_USED: assert property (@(posedge clk) disable iff (!rst_n)
        (state == PDC_MOVER_IDLE) && dma.start |=> burst_host_addr == $past(dma.base))
        else $error("transfer did not start at host buffer base");
endmodule

/* rtl/pdc_button_irq.sv */
/*
 * Push-button press detector that raises one interrupt message per press.
 * Assumes the button is an asynchronous, active-high level from a pin.
 */
module pdc_button_irq (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic button,
    input  wire logic irq_enable,
    input  wire logic irq_clear,
    output logic      irq_pending,
    output logic      irq_msg
);
    logic sync1;
    logic sync2;
    logic last;

    // press seen on the second stage only
    wire logic press = sync2 && !last;
    wire logic fire  = press && irq_enable;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1       <= 1'b0;
            sync2       <= 1'b0;
            last        <= 1'b0;
            irq_pending <= 1'b0;
            irq_msg     <= 1'b0;
        end else begin
            sync1 <= button;
            sync2 <= sync1;
            last  <= sync2;
            irq_msg <= fire;
            // a press in the clearing cycle still lands
            if (fire) begin
                irq_pending <= 1'b1;
            end else if (irq_clear || !irq_enable) begin
                irq_pending <= 1'b0;
            end
        end
    end

    AST_PRESS_MSG: assert property (@(posedge clk) disable iff (!rst_n)
        sync2 && !last && irq_enable |=> irq_msg && irq_pending)
        else $error("button press raised no interrupt");

    AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
        !irq_enable |=> !irq_msg && !irq_pending)
        else $error("interrupt raised while disabled");
endmodule

/* rtl/pdc_ctrl_regs.sv */
/*
 * Transfer control register bank behind the two host address windows:
 * scratch word, transfer setup and status, LED walk, lamps and DIP switches.
 * Assumes a single-clock host request port (one request per valid cycle),
 * a fabric burst sink on the same clock, and asynchronous board pins.
 */
`include "pdc_defines.svh"

module pdc_ctrl_regs
    import pdc_pkg::*;
#(
    parameter int STEP_CYCLES = `PDC_WALK_STEP_MS * `PDC_CLK_KHZ
)
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   req_valid,
    input  wire logic                   req_write,
    input  wire logic                   req_bar,
    input  wire logic [`PDC_ADDR_W-1:0] req_addr,
    input  wire logic [31:0]            req_wdata,
    output logic                        rsp_valid,
    output logic [31:0]                 rsp_data,
    output logic                        burst_valid,
    input  wire logic                   burst_ready,
    output logic                        burst_to_host,
    output logic [31:0]                 burst_host_addr,
    output logic [31:0]                 burst_sram_addr,
    output logic [`PDC_LAMP_W-1:0]      led_out,
    output logic                        walk_active,
    input  wire logic [`PDC_DIP_W-1:0]  dip_sw,
    input  wire logic                   interrupt_push_button,
    input  wire logic                   irq_enable,
    input  wire logic                   irq_clear,
    output logic                        irq_pending,
    output logic                        irq_msg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // storage

    logic [31:0]            scratch_word;
    logic [31:0]            transfer_direction_code;
    logic [31:0]            transfer_length;
    logic [31:0]            host_buffer_base;
    logic [31:0]            cpu_led_walk_key;
    logic [`PDC_LAMP_W-1:0] lamp_outputs;
    logic [`PDC_DIP_W-1:0]  dip_sync1;
    logic [`PDC_DIP_W-1:0]  dip_inputs;
    logic                   start;
    logic [31:0]            step_count;
    logic [`PDC_LAMP_W-1:0] walk_pattern;

    pdc_dma_if dma ();

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire logic wr       = req_valid && req_write;
    wire logic rd       = req_valid && !req_write;
    wire logic hit_w1   = req_bar;
    wire logic hit_w0   = !req_bar;

    wire logic sel_scratch = hit_w1 && (req_addr == `PDC_OFS_SCRATCH);
    wire logic sel_dir     = hit_w1 && (req_addr == `PDC_OFS_DIR);
    wire logic sel_len     = hit_w1 && (req_addr == `PDC_OFS_LEN);
    wire logic sel_cycles  = hit_w1 && (req_addr == `PDC_OFS_CYCLES);
    wire logic sel_done    = hit_w1 && (req_addr == `PDC_OFS_DONE);
    wire logic sel_base    = hit_w1 && (req_addr == `PDC_OFS_BASE);
    wire logic sel_key     = hit_w1 && (req_addr == `PDC_OFS_WALK_KEY);
    wire logic sel_dip     = hit_w0 && (req_addr == `PDC_OFS_DIP);
    wire logic sel_lamp    = hit_w0 && (req_addr == `PDC_OFS_LAMP);

    // direction code written last acts as the go command
    wire logic dir_valid = (req_wdata == `PDC_DIR_TO_HOST)
                        || (req_wdata == `PDC_DIR_TO_SRAM);
    wire logic len_valid = (transfer_length == `PDC_LEN_8K)
                        || (transfer_length == `PDC_LEN_16K)
                        || (transfer_length == `PDC_LEN_32K);
    // a start while busy, or with a bad length, is dropped
    wire logic next_start = wr && sel_dir && dir_valid && len_valid
                         && !dma.busy && !start;

    wire logic [31:0] dip_word  = {{(32-`PDC_DIP_LSB-`PDC_DIP_W){1'b0}},
                                   dip_inputs, {`PDC_DIP_LSB{1'b0}}};
    wire logic [31:0] lamp_word = {{(32-`PDC_LAMP_W){1'b0}}, lamp_outputs};
    wire logic [31:0] done_word = {31'h00000000, dma.done};

    wire logic [31:0] rd_mux =
        sel_scratch ? scratch_word :
        sel_dir     ? transfer_direction_code :
        sel_len     ? transfer_length :
        sel_cycles  ? dma.cycles :
        sel_done    ? done_word :
        sel_base    ? host_buffer_base :
        sel_key     ? cpu_led_walk_key :
        sel_dip     ? dip_word :
        sel_lamp    ? lamp_word :
                      `PDC_REG_RESET;

    assign dma.start   = start;
    assign dma.to_host = (transfer_direction_code == `PDC_DIR_TO_HOST);
    assign dma.length  = transfer_length;
    assign dma.base    = host_buffer_base;

    ////////////////////////////////////////////////////////////////////////
    // host-written registers

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scratch_word            <= `PDC_REG_RESET;
            transfer_direction_code <= `PDC_REG_RESET;
            transfer_length         <= `PDC_REG_RESET;
            host_buffer_base        <= `PDC_REG_RESET;
            cpu_led_walk_key        <= `PDC_REG_RESET;
            lamp_outputs            <= '0;
            start                   <= 1'b0;
        end else begin
            start <= next_start;
            if (wr && sel_scratch) begin
                scratch_word <= req_wdata;
            end
            if (wr && sel_dir) begin
                transfer_direction_code <= req_wdata;
            end
            if (wr && sel_len) begin
                transfer_length <= req_wdata;
            end
            if (wr && sel_base) begin
                host_buffer_base <= req_wdata;
            end
            if (wr && sel_key) begin
                cpu_led_walk_key <= req_wdata;
            end
            if (wr && sel_lamp) begin
                lamp_outputs <= req_wdata[`PDC_LAMP_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read answer, one cycle after the request

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rsp_valid <= 1'b0;
            rsp_data  <= `PDC_REG_RESET;
        end else begin
            rsp_valid <= rd;
            if (rd) begin
                rsp_data <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // switches: pins pass two flops before the read path sees them

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dip_sync1  <= '0;
            dip_inputs <= '0;
        end else begin
            dip_sync1  <= dip_sw;
            dip_inputs <= dip_sync1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // LED walk: own divider, untouched by transfer state

    assign walk_active = (cpu_led_walk_key == `PDC_WALK_KEY);
    wire logic step_en = walk_active && (step_count == 32'(STEP_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            step_count   <= `PDC_REG_RESET;
            walk_pattern <= `PDC_LAMP_SEED;
            led_out      <= '0;
        end else begin
            if (!walk_active || step_en) begin
                step_count <= `PDC_REG_RESET;
            end else begin
                step_count <= step_count + 32'h00000001;
            end
            if (!walk_active) begin
                walk_pattern <= `PDC_LAMP_SEED;
            end else if (step_en) begin
                walk_pattern <= {walk_pattern[`PDC_LAMP_W-2:0],
                                 walk_pattern[`PDC_LAMP_W-1]};
            end
            // lamps never wait on the mover
            led_out <= walk_active ? walk_pattern : lamp_outputs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers

    pdc_burst_mover u_mover (
        .clk             (clk),
        .rst_n           (rst_n),
        .dma             (dma.mover),
        .burst_valid     (burst_valid),
        .burst_ready     (burst_ready),
        .burst_to_host   (burst_to_host),
        .burst_host_addr (burst_host_addr),
        .burst_sram_addr (burst_sram_addr)
    );

    pdc_button_irq u_button (
        .clk         (clk),
        .rst_n       (rst_n),
        .button      (interrupt_push_button),
        .irq_enable  (irq_enable),
        .irq_clear   (irq_clear),
        .irq_pending (irq_pending),
        .irq_msg     (irq_msg)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_START_ON_CODE: assert property (
        wr && sel_dir && dir_valid && len_valid && !dma.busy && !start
        |=> start ##1 burst_valid && burst_to_host == $past(dma.to_host))
        else $error("valid direction code did not start a transfer");

    AST_BAD_LEN_NO_START: assert property (
        start |-> $past(len_valid))
        else $error("transfer started with an unsupported length");

    AST_DONE_READ: assert property (
        rd && sel_done |=> rsp_valid && rsp_data == {31'h00000000, $past(dma.done)})
        else $error("completion word read back wrong");

    AST_START_CLEARS: assert property (
        start |=> !dma.done && dma.cycles == 32'h00000000)
        else $error("start did not clear done flag and counter");

    AST_CYCLES_READ: assert property (
        rd && sel_cycles |=> rsp_data == $past(dma.cycles))
        else $error("cycle count read back wrong");

    AST_SCRATCH_ECHO: assert property (
        wr && sel_scratch ##1 rd && sel_scratch |=> rsp_data == $past(req_wdata, 2))
        else $error("scratch word did not echo last write");

    AST_LAMP_FOLLOW: assert property (
        !walk_active ##1 !walk_active |-> led_out == $past(lamp_outputs))
        else $error("lamps do not follow control field");

    AST_DIP_TRACK: assert property (
        rd && sel_dip |=> rsp_data[`PDC_DIP_LSB+`PDC_DIP_W-1:`PDC_DIP_LSB] == $past(dip_inputs))
        else $error("switch field does not track switches");

    AST_WALK_ONLY_KEY: assert property (
        !walk_active |=> walk_pattern == `PDC_LAMP_SEED && step_count == 32'h00000000)
        else $error("walk advanced without key value");

    AST_WALK_ROTATE: assert property (
        step_en |=> walk_pattern == {$past(walk_pattern[`PDC_LAMP_W-2:0]),
                                     $past(walk_pattern[`PDC_LAMP_W-1])})
        else $error("walk did not step one lamp");

    AST_DIR_STORE: assert property (
        wr && sel_dir |=> transfer_direction_code == $past(req_wdata))
        else $error("direction code not stored");

    AST_LAMP_WRITE: assert property (
        wr && sel_lamp |=> lamp_outputs == $past(req_wdata[`PDC_LAMP_W-1:0]))
        else $error("lamp field not stored");

    AST_WALK_DURING_XFER: assert property (
        step_en && dma.busy |=> walk_pattern != $past(walk_pattern))
        else $error("walk stalled while a transfer ran");
endmodule

/* rtl/pdc_defines.svh */
/*
 * Offsets, key codes, field positions, reset values and timing figures of the
 * transfer control register bank.
 * Assumes inclusion by bare name from files on the rtl/ include path.
 */
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

`define PDC_ADDR_W          17
// second window (bar select = 1)
`define PDC_OFS_SCRATCH     17'h00000
`define PDC_OFS_DIR         17'h08008
`define PDC_OFS_LEN         17'h08010
`define PDC_OFS_CYCLES      17'h08018
`define PDC_OFS_DONE        17'h08020
`define PDC_OFS_BASE        17'h08028
`define PDC_OFS_WALK_KEY    17'h08030
// first window (bar select = 0)
`define PDC_OFS_DIP         17'h13080
`define PDC_OFS_LAMP        17'h13088

`define PDC_DIR_TO_HOST     32'h11aa1111
`define PDC_DIR_TO_SRAM     32'h11aa2222
`define PDC_LEN_8K          32'h00002000
`define PDC_LEN_16K         32'h00004000
`define PDC_LEN_32K         32'h00008000
`define PDC_WALK_KEY        32'h11aa0f0f
`define PDC_BURST_BYTES     32'h00000020

`define PDC_DIP_LSB         8
`define PDC_DIP_W           4
`define PDC_LAMP_W          8
`define PDC_REG_RESET       32'h00000000
`define PDC_LAMP_SEED       8'h01

`define PDC_CLK_KHZ         50000
`define PDC_WALK_STEP_MS    100

`endif

/* rtl/pdc_dma_if.sv */
/*
 * Request and result lines between the register bank and the burst mover.
 * Assumes both ends sit on the same clock.
 */
interface pdc_dma_if;
    logic        start;
    logic        to_host;
    logic [31:0] length;
    logic [31:0] base;
    logic        busy;
    logic        done;
    logic [31:0] cycles;

    modport ctrl  (output start, to_host, length, base, input busy, done, cycles);
    modport mover (input start, to_host, length, base, output busy, done, cycles);
endinterface

/* rtl/pdc_pkg.sv */
/*
 * Types shared by the transfer control register bank and its helpers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pdc_pkg;
    typedef enum logic [1:0] {
        PDC_MOVER_IDLE,
        PDC_MOVER_RUN
    } pdc_mover_state_type;
endpackage

/* test/pdc_host_model.sv */
/*
 * Host-side partner: issues register requests and acts as the burst sink.
 * Assumes the bank takes a request on the rising edge with req_valid high.
 */
`include "pdc_defines.svh"

module pdc_host_model (
    input  wire logic              clk,
    output logic                   req_valid,
    output logic                   req_write,
    output logic                   req_bar,
    output logic [`PDC_ADDR_W-1:0] req_addr,
    output logic [31:0]            req_wdata,
    input  wire logic              rsp_valid,
    input  wire logic [31:0]       rsp_data,
    output logic                   burst_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       slow = 1'b0;
    logic [1:0] ph   = 2'h0;

    initial begin
        req_valid   = 1'b0;
        req_write   = 1'b0;
        req_bar     = 1'b0;
        req_addr    = '0;
        req_wdata   = '0;
        burst_ready = 1'b1;
    end

    // slow mode accepts one burst in four, so the mover must hold its request
    always @(posedge clk) begin
        #1;
        ph          = ph + 2'h1;
        burst_ready = !slow || (ph == 2'h0);
    end

    task automatic issue(input logic wr, input logic bar, input logic [16:0] addr,
                         input logic [31:0] data);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = wr;
        req_bar   = bar;
        req_addr  = addr;
        req_wdata = data;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        // released address and data lines never keep the last value
        req_addr  = ~req_addr;
        req_wdata = ~req_wdata;
    endtask

    task automatic wr(input logic bar, input logic [16:0] addr, input logic [31:0] data);
        issue(1'b1, bar, addr, data);
    endtask

    task automatic rd(input logic bar, input logic [16:0] addr, output logic [31:0] data);
        issue(1'b0, bar, addr, 32'h0);
        for (int i = 0; i < 4 && !rsp_valid; i++) begin
            @(posedge clk);
            #1;
        end
        data = rsp_valid ? rsp_data : 32'hdead_beef;
    endtask

    // write then read the same word in the next cycle, no idle gap
    task automatic wr_rd(input logic bar, input logic [16:0] addr, input logic [31:0] data,
                         output logic [31:0] q);
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_write = 1'b1;
        req_bar   = bar;
        req_addr  = addr;
        req_wdata = data;
        @(posedge clk);
        #1;
        req_write = 1'b0;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        q         = rsp_valid ? rsp_data : 32'hdead_beef;
    endtask

    // setup first, direction last since it starts the transfer
    task automatic setup_xfer(input logic [31:0] base, len, dir);
        wr(1'b1, `PDC_OFS_BASE, base);
        wr(1'b1, `PDC_OFS_LEN, len);
        wr(1'b1, `PDC_OFS_DIR, dir);
    endtask
endmodule

/* test/testbench.sv */
/*
 * Self-checking bench for the transfer control register bank.
 * Assumes the host partner model and a 50 MHz clock.
 */
`include "pdc_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pdc_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, rsp_valid, burst_valid, burst_ready, burst_to_host;
    logic req_valid, req_write, req_bar, walk_active, irq_pending, irq_msg;
    logic push = 1'b0, irq_enable = 1'b0, irq_clear = 1'b0;
    logic [16:0] req_addr;
    logic [31:0] req_wdata, rsp_data, burst_host_addr, burst_sram_addr, d, exp_host, exp_sram;
    logic [7:0]  led_out, seen;
    logic [3:0]  dip_sw = 4'h0;
    int n_mismatch = 0, comparisons = 0, cyc = 0, takes = 0, vcnt = 0, msgs = 0;

    initial forever #10 clk = ~clk;

    pdc_ctrl_regs #(.STEP_CYCLES(4)) u_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_write(req_write), .req_bar(req_bar), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .burst_valid(burst_valid), .burst_ready(burst_ready),
        .burst_to_host(burst_to_host), .burst_host_addr(burst_host_addr),
        .burst_sram_addr(burst_sram_addr), .led_out(led_out), .walk_active(walk_active),
        .dip_sw(dip_sw), .interrupt_push_button(push), .irq_enable(irq_enable),
        .irq_clear(irq_clear), .irq_pending(irq_pending), .irq_msg(irq_msg));

    pdc_host_model u_host (.clk(clk), .req_valid(req_valid), .req_write(req_write),
        .req_bar(req_bar), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .burst_ready(burst_ready));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // mid-cycle sampling keeps clear of the edge that updates the outputs
    always @(negedge clk) begin
        cyc++;
        if (cyc > 30000) begin
            n_mismatch++;
            stop_test();
        end
        if (burst_valid)
            vcnt++;
        if (burst_valid && burst_ready) begin
            chk("burst host addr", exp_host, burst_host_addr);
            chk("burst sram addr", exp_sram, burst_sram_addr);
            exp_host += 32'h20;
            exp_sram += 32'h20;
            takes++;
        end
        if (irq_msg)
            msgs++;
    end

    task automatic t_reset();
        logic [16:0] ofs [8] = '{`PDC_OFS_SCRATCH, `PDC_OFS_DIR, `PDC_OFS_LEN,
            `PDC_OFS_CYCLES, `PDC_OFS_DONE, `PDC_OFS_BASE, `PDC_OFS_WALK_KEY, 17'h00100};
        foreach (ofs[i]) begin
            u_host.rd(1'b1, ofs[i], d);
            chk("reset value", `PDC_REG_RESET, d);
        end
        chk("reset lamps", 32'h0, {24'h0, led_out});
        $display("test reset done");
    endtask

    task automatic t_scratch();
        u_host.wr(1'b1, `PDC_OFS_SCRATCH, 32'ha5c3_0f96);
        u_host.wr(1'b1, `PDC_OFS_CYCLES, 32'h1234_5678);
        u_host.rd(1'b1, `PDC_OFS_SCRATCH, d);
        chk("scratch word", 32'ha5c3_0f96, d);
        u_host.wr_rd(1'b1, `PDC_OFS_SCRATCH, 32'h5a3c_c3a5, d);
        chk("scratch back to back", 32'h5a3c_c3a5, d);
        u_host.rd(1'b1, `PDC_OFS_CYCLES, d);
        chk("cycle count read-only", 32'h0, d);
        $display("test scratch done");
    endtask

    task automatic xfer(input logic [31:0] dir, len, input logic slow, input logic go);
        exp_host    = 32'h8765_4320;
        exp_sram    = 32'h0;
        takes       = 0;
        vcnt        = 0;
        u_host.slow = slow;
        u_host.setup_xfer(exp_host, len, dir);
        repeat (2) @(posedge clk);
        u_host.rd(1'b1, `PDC_OFS_DONE, d);
        chk("done while running", go ? 32'h0 : 32'h1, d);
        for (int i = 0; i < 2500 && d !== 32'h1; i++)
            u_host.rd(1'b1, `PDC_OFS_DONE, d);
        chk("done flag", 32'h1, d);
        chk("burst count", go ? len / 32 : 0, takes);
        if (go) begin
            chk("direction", {31'h0, dir == `PDC_DIR_TO_HOST}, {31'h0, burst_to_host});
            u_host.rd(1'b1, `PDC_OFS_CYCLES, d);
            chk("cycle count", vcnt, d);
        end
    endtask

    task automatic t_xfer();
        logic [31:0] lens [3] = '{`PDC_LEN_8K, `PDC_LEN_16K, `PDC_LEN_32K};
        u_host.wr(1'b1, `PDC_OFS_WALK_KEY, `PDC_WALK_KEY);
        foreach (lens[i]) begin
            xfer(`PDC_DIR_TO_HOST, lens[i], i[0], 1'b1);
            xfer(`PDC_DIR_TO_SRAM, lens[i], !i[0], 1'b1);
        end
        xfer(32'h11aa3333, `PDC_LEN_8K, 1'b0, 1'b0);
        xfer(`PDC_DIR_TO_HOST, 32'h0000_1000, 1'b0, 1'b0);
        chk("walk kept during transfers", 32'h1, {31'h0, walk_active});
        $display("test transfer done");
    endtask

    task automatic t_led();
        repeat (3) @(posedge clk);
        #1 seen = led_out;
        for (int i = 0; i < 12 && led_out === seen; i++) begin
            @(posedge clk);
            #1;
        end
        chk("walk step", {24'h0, seen[6:0], seen[7]}, {24'h0, led_out});
        u_host.wr(1'b1, `PDC_OFS_WALK_KEY, 32'h11aa0f0e);
        u_host.wr(1'b0, `PDC_OFS_LAMP, 32'h0000_005a);
        repeat (3) @(posedge clk);
        #1;
        chk("walk off", 32'h0, {31'h0, walk_active});
        chk("lamps", 32'h5a, {24'h0, led_out});
        dip_sw = 4'ha;
        repeat (3) @(posedge clk);
        u_host.rd(1'b0, `PDC_OFS_DIP, d);
        chk("dip field", 32'ha, {28'h0, d[11:8]});
        $display("test led and dip done");
    endtask

    task automatic press();
        @(posedge clk);
        #1 push = 1'b1;
        repeat (4) @(posedge clk);
        #1 push = 1'b0;
        repeat (6) @(posedge clk);
    endtask

    task automatic t_irq();
        irq_enable = 1'b1;
        msgs       = 0;
        press();
        chk("irq messages", 32'h1, msgs);
        chk("irq pending", 32'h1, {31'h0, irq_pending});
        #1 irq_clear = 1'b1;
        @(posedge clk);
        #1 irq_clear = 1'b0;
        @(posedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq_pending});
        #1 irq_enable = 1'b0;
        press();
        chk("irq disabled", 32'h1, msgs);
        chk("irq pending off", 32'h0, {31'h0, irq_pending});
        $display("test interrupt done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_scratch();
        t_xfer();
        t_led();
        t_irq();
        stop_test();
    end
endmodule
